// [inc/adccal_params.svh]
// Offsets, field positions, reset values and timing counts of the
// calibration, averaging and correction block.
// Assumes inclusion by bare name from the design file.
`ifndef ADCCAL_PARAMS_SVH
`define ADCCAL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define ADCCAL_OFF_CTRL   8'h20
`define ADCCAL_OFF_OFS    8'h24
`define ADCCAL_OFF_GAIN   8'h2C
`define ADCCAL_OFF_PLUS_CAL_VALUE_D   8'h34
`define ADCCAL_OFF_PLUS_CAL_VALUE_S   8'h38
`define ADCCAL_OFF_PLUS_CAL_VALUE_4   8'h3C
`define ADCCAL_OFF_PLUS_CAL_VALUE_3   8'h40
`define ADCCAL_OFF_PLUS_CAL_VALUE_2   8'h44
`define ADCCAL_OFF_PLUS_CAL_VALUE_1   8'h48
`define ADCCAL_OFF_PLUS_CAL_VALUE_0   8'h4C
`define ADCCAL_OFF_IRQST  8'h60
`define ADCCAL_OFF_IRQMSK 8'h64
`define ADCCAL_OFF_START  8'h68

// ----------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------
`define ADCCAL_B_CAL  7
`define ADCCAL_B_CALIBRATION_FAILED_FLAG 6
`define ADCCAL_B_CONT 3
`define ADCCAL_B_AVERAGE_ENABLE 2

// ----------------------------------------------------------------------
// Interrupt status bits.
// ----------------------------------------------------------------------
`define ADCCAL_IRQ_CALDONE 0
`define ADCCAL_IRQ_CALFAIL 1
`define ADCCAL_IRQ_RESULT  2

// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define ADCCAL_GAIN_RST   16'h8000
`define ADCCAL_CAL_CYCLES 16'h0040

`endif

// [inc/adccal_pkg.sv]
// Types shared by the calibration, averaging and correction block.
// Assumes nothing of its surroundings.
package adccal_pkg;

    typedef enum logic [1:0] {
        ADCCAL_IDLE = 2'b00,
        ADCCAL_CONV = 2'b01,
        ADCCAL_CAL  = 2'b10
    } adccal_state_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } adccal_bus_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } adccal_sample_type;

endpackage : adccal_pkg

// [src/adccal_core.sv]
// Calibration sequencer, conversion mode control, hardware averaging,
// offset correction with saturation and the calibration value registers.
// Assumes an analog core that returns left-justified 16-bit samples and
// a single 20 MHz clock; all inputs are synchronous to sys_clk.
//
// Overview of operation
// RULE1: Calibration start bit stays one during calibration, clears at its end.
// RULE2: Any register write during calibration invalidates it and sets failed flag.
// RULE3: Setting calibration start aborts the conversion now in progress.
// RULE4: Hardware trigger selected or stop mode entered fails the calibration.
// RULE5: Failed flag reads zero after normal completion, one after failure.
// RULE6: Writing one clears the failed flag; writing zero leaves it.
// RULE7: Continuous bit zero gives one conversion or set; one repeats them.
// RULE8: Average enable bit turns multi-sample averaging on or off.
// RULE9: Count select codes 00..11 choose 4, 8, 16 or 32 samples.
// RULE10: Offset value is subtracted from each conversion before the result.
// RULE11: Corrected result is saturated to the limits of the result mode.
// RULE12: Gain register holds a 16-bit unsigned factor, integer bit fifteen.
// RULE13: Software must load the gain register with the calibrated value.
// RULE14: Seven plus-side calibration values of widths 6,7,8,9,10,6,6.
// RULE15: Completed calibration loads all calibration values automatically.
// RULE16: Reserved bits read as zero and ignore writes.
// RULE17: Average sums the selected samples and divides by the count.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps

`include "adccal_params.svh"

module adccal_core
    import adccal_pkg::*;
#(
    parameter int RES_BITS = 16    // Result width for the current mode.
) (
    input  wire logic              sys_clk,       // 20 MHz clock.
    input  wire logic              rst,           // Synchronous reset.
    input  wire adccal_bus_type    bus,           // Register request.
    output logic [31:0]            rdata,         // Read data, next cycle.
    input  wire logic              trigger_select,// One: hardware trigger.
    input  wire logic              stop_mode,     // Stop mode entered.
    input  wire logic              hw_trigger,    // Hardware start pulse.
    input  wire adccal_sample_type sample,        // Raw conversion result.
    input  wire logic [31:0]       cal_measure,   // Core calibration data.
    output logic                   conv_start,    // Starts one conversion.
    output logic                   conv_abort,    // Aborts conversion.
    output logic                   conv_active,   // Conversion or set busy.
    output adccal_sample_type      result,        // Corrected result.
    output logic [15:0]            gain_factor,   // Gain to analog path.
    output logic                   irq            // Level interrupt.
);

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    adccal_state_type state_q;
    logic             cal_q;
    logic             calibration_failed_flag_q;
    logic             cont_q;
    logic             average_enable_q;
    logic [1:0]       average_count_select_q;
    logic [15:0]      ofs_q;
    logic [15:0]      gain_q;
    logic [5:0]       plus_cal_value_d_q;
    logic [5:0]       plus_cal_value_s_q;
    logic [9:0]       plus_cal_value_4_q;
    logic [8:0]       plus_cal_value_3_q;
    logic [7:0]       plus_cal_value_2_q;
    logic [6:0]       plus_cal_value_1_q;
    logic [5:0]       plus_cal_value_0_q;
    logic [2:0]       irq_st_q;
    logic [2:0]       irq_msk_q;
    logic [15:0]      cal_cnt_q;
    logic [20:0]      acc_q;
    logic [5:0]       smp_cnt_q;
    logic             cal_bad_q;
    logic             issue_q;

    logic             wr_ctrl;
    logic             cal_set;
    logic             cal_end;
    logic             cal_fail_now;
    logic             sw_start;
    logic [5:0]       smp_target;
    logic [20:0]      acc_d;
    logic [15:0]      avg_val;
    logic             set_done;

    assign wr_ctrl  = bus.wr && bus.addr == `ADCCAL_OFF_CTRL;
    assign cal_set  = wr_ctrl && bus.wdata[`ADCCAL_B_CAL] && !cal_q;
    assign sw_start = bus.wr && bus.addr == `ADCCAL_OFF_START;
    assign cal_end  = state_q == ADCCAL_CAL && cal_cnt_q == 16'h0000;
    // Any write while calibrating, hardware trigger or stop mode spoils it.
    assign cal_fail_now = cal_q && (bus.wr || trigger_select   // see RULE2
                                    || stop_mode);             // see RULE4

    // ------------------------------------------------------------------
    // Calibration sequencer and conversion state.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q   <= ADCCAL_IDLE;
            cal_q     <= 1'b0;
            cal_cnt_q <= 16'h0000;
            cal_bad_q <= 1'b0;
            issue_q   <= 1'b0;
        end else begin
            issue_q <= 1'b0;
            if (cal_set) begin
                state_q   <= ADCCAL_CAL;                      // see RULE3
                cal_q     <= 1'b1;                            // see RULE1
                cal_cnt_q <= `ADCCAL_CAL_CYCLES;
                cal_bad_q <= trigger_select || stop_mode;     // see RULE4
            end else begin
                unique case (state_q)
                    ADCCAL_IDLE: begin
                        if (sw_start && !trigger_select
                            || hw_trigger && trigger_select) begin
                            state_q <= ADCCAL_CONV;
                            issue_q <= 1'b1;
                        end
                    end
                    ADCCAL_CONV: begin
                        if (set_done && !cont_q) begin        // see RULE7
                            state_q <= ADCCAL_IDLE;
                        end else if (sample.valid) begin
                            issue_q <= 1'b1;
                        end
                    end
                    ADCCAL_CAL: begin
                        if (cal_fail_now) begin
                            cal_bad_q <= 1'b1;
                        end
                        if (cal_end) begin
                            state_q <= ADCCAL_IDLE;
                            cal_q   <= 1'b0;                  // see RULE1
                        end else begin
                            cal_cnt_q <= cal_cnt_q - 16'h0001;
                        end
                    end
                    default: state_q <= ADCCAL_IDLE;
                endcase
            end
        end
    end

    // Failed flag: hardware set wins over a simultaneous write-one clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            calibration_failed_flag_q <= 1'b0;
        end else if (cal_end && (cal_bad_q || cal_fail_now)) begin
            calibration_failed_flag_q <= 1'b1;                                   // see RULE5
        end else if (cal_set) begin
            calibration_failed_flag_q <= 1'b0;                                   // see RULE5
        end else if (wr_ctrl && bus.wdata[`ADCCAL_B_CALIBRATION_FAILED_FLAG]) begin
            calibration_failed_flag_q <= 1'b0;                                   // see RULE6
        end
    end

    // ------------------------------------------------------------------
    // Software-written configuration.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cont_q <= 1'b0;
            average_enable_q <= 1'b0;
            average_count_select_q <= 2'b00;
            ofs_q  <= 16'h0000;
            gain_q <= `ADCCAL_GAIN_RST;
        end else if (bus.wr) begin
            if (bus.addr == `ADCCAL_OFF_CTRL) begin
                cont_q <= bus.wdata[`ADCCAL_B_CONT];
                average_enable_q <= bus.wdata[`ADCCAL_B_AVERAGE_ENABLE];          // see RULE8
                average_count_select_q <= bus.wdata[1:0];                     // see RULE9
            end
            if (bus.addr == `ADCCAL_OFF_OFS) begin
                ofs_q <= bus.wdata[15:0];
            end
            if (bus.addr == `ADCCAL_OFF_GAIN) begin
                gain_q <= bus.wdata[15:0];                    // see RULE12
            end
        end
    end

    // Calibration values: software may write, completion reloads them.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            plus_cal_value_d_q <= 6'h00;
            plus_cal_value_s_q <= 6'h00;
            plus_cal_value_4_q <= 10'h000;
            plus_cal_value_3_q <= 9'h000;
            plus_cal_value_2_q <= 8'h00;
            plus_cal_value_1_q <= 7'h00;
            plus_cal_value_0_q <= 6'h00;
        end else if (cal_end) begin
            plus_cal_value_d_q <= cal_measure[5:0];                       // see RULE15
            plus_cal_value_s_q <= cal_measure[11:6];
            plus_cal_value_4_q <= cal_measure[9:0];
            plus_cal_value_3_q <= cal_measure[8:0];
            plus_cal_value_2_q <= cal_measure[7:0];
            plus_cal_value_1_q <= cal_measure[6:0];
            plus_cal_value_0_q <= cal_measure[5:0];
        end else if (bus.wr) begin
            unique case (bus.addr)                            // see RULE14
                `ADCCAL_OFF_PLUS_CAL_VALUE_D: plus_cal_value_d_q <= bus.wdata[5:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_S: plus_cal_value_s_q <= bus.wdata[5:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_4: plus_cal_value_4_q <= bus.wdata[9:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_3: plus_cal_value_3_q <= bus.wdata[8:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_2: plus_cal_value_2_q <= bus.wdata[7:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_1: plus_cal_value_1_q <= bus.wdata[6:0];
                `ADCCAL_OFF_PLUS_CAL_VALUE_0: plus_cal_value_0_q <= bus.wdata[5:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Averaging, offset subtraction and saturation.
    // ------------------------------------------------------------------
    always_comb begin
        smp_target = 6'd1;
        if (average_enable_q) begin
            unique case (average_count_select_q)                              // see RULE9
                2'b00: smp_target = 6'd4;
                2'b01: smp_target = 6'd8;
                2'b10: smp_target = 6'd16;
                2'b11: smp_target = 6'd32;
            endcase
        end
    end

    assign acc_d    = acc_q + {5'h00, sample.data};           // see RULE17
    // A sample landing in the abort cycle belongs to the aborted set.
    assign set_done = state_q == ADCCAL_CONV && sample.valid && !cal_set
                      && smp_cnt_q + 6'd1 == smp_target;

    always_comb begin
        avg_val = acc_d[15:0];
        if (average_enable_q) begin
            unique case (average_count_select_q)                              // see RULE17
                2'b00: avg_val = acc_d[17:2];
                2'b01: avg_val = acc_d[18:3];
                2'b10: avg_val = acc_d[19:4];
                2'b11: avg_val = acc_d[20:5];
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || state_q != ADCCAL_CONV) begin
            acc_q     <= 21'h00_0000;
            smp_cnt_q <= 6'd0;
        end else if (sample.valid) begin
            acc_q     <= set_done ? 21'h00_0000 : acc_d;
            smp_cnt_q <= set_done ? 6'd0 : smp_cnt_q + 6'd1;
        end
    end

    // Subtract in 18 bits so neither limit can wrap.
    logic signed [17:0] diff;
    logic        [15:0] max_val;
    assign max_val = 16'hFFFF << (16 - RES_BITS);
    assign diff = $signed({2'b00, avg_val})
                - $signed({{2{ofs_q[15]}}, ofs_q});           // see RULE10

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result <= '0;
        end else begin
            result.valid <= set_done;
            if (set_done) begin
                if (diff < 18'sd0) begin
                    result.data <= 16'h0000;                  // see RULE11
                end else if (diff > $signed({2'b00, max_val})) begin
                    result.data <= max_val;                   // see RULE11
                end else begin
                    result.data <= diff[15:0] & max_val;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_st_q  <= 3'h0;
            irq_msk_q <= 3'h0;
        end else begin
            if (bus.wr && bus.addr == `ADCCAL_OFF_IRQMSK) begin
                irq_msk_q <= bus.wdata[2:0];
            end
            irq_st_q <= (irq_st_q
                         & ~({3{bus.wr && bus.addr == `ADCCAL_OFF_IRQST}}
                             & bus.wdata[2:0]))
                      | {result.valid,
                         cal_end && (cal_bad_q || cal_fail_now),
                         cal_end};
        end
    end

    assign irq = |(irq_st_q & irq_msk_q);

    // ------------------------------------------------------------------
    // Read port and outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= 32'h0000_0000;                           // see RULE16
            if (bus.rd) begin
                unique case (bus.addr)
                    `ADCCAL_OFF_CTRL:
                        rdata[7:0] <= {cal_q, calibration_failed_flag_q, 2'b00, cont_q,
                                       average_enable_q, average_count_select_q};
                    `ADCCAL_OFF_OFS:    rdata[15:0] <= ofs_q;
                    `ADCCAL_OFF_GAIN:   rdata[15:0] <= gain_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_D:   rdata[5:0]  <= plus_cal_value_d_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_S:   rdata[5:0]  <= plus_cal_value_s_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_4:   rdata[9:0]  <= plus_cal_value_4_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_3:   rdata[8:0]  <= plus_cal_value_3_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_2:   rdata[7:0]  <= plus_cal_value_2_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_1:   rdata[6:0]  <= plus_cal_value_1_q;
                    `ADCCAL_OFF_PLUS_CAL_VALUE_0:   rdata[5:0]  <= plus_cal_value_0_q;
                    `ADCCAL_OFF_IRQST:  rdata[2:0]  <= irq_st_q;
                    `ADCCAL_OFF_IRQMSK: rdata[2:0]  <= irq_msk_q;
                    default: ;
                endcase
            end
        end
    end

    assign conv_start  = issue_q;
    assign conv_abort  = cal_set && state_q == ADCCAL_CONV;   // see RULE3
    assign conv_active = state_q == ADCCAL_CONV;
    assign gain_factor = gain_q;                              // see RULE13

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_CAL_HOLD: assert property (cal_set |=> cal_q [*8]) // see RULE1
        else $error("Calibration bit dropped early.");
    AST_CAL_CLR: assert property (cal_end |=> !cal_q) // see RULE1
        else $error("Calibration bit not cleared at end.");
    AST_WR_FAIL: assert property (cal_q && bus.wr && !cal_end
                                  |=> cal_bad_q) // see RULE2
        else $error("Write during calibration not recorded.");
    AST_ABORT: assert property (cal_set && conv_active |-> conv_abort
                                ##1 !conv_active) // see RULE3
        else $error("Conversion not aborted by calibration.");
    AST_TRIG_FAIL: assert property (cal_end && trigger_select
                                    |=> calibration_failed_flag_q) // see RULE4
        else $error("Hardware trigger did not fail calibration.");
    AST_OK: assert property (cal_end && !cal_bad_q && !cal_fail_now
                             |=> !calibration_failed_flag_q) // see RULE5
        else $error("Clean calibration reported failure.");
    AST_W1C: assert property (calibration_failed_flag_q && wr_ctrl && !cal_end
                              && bus.wdata[`ADCCAL_B_CALIBRATION_FAILED_FLAG]
                              |=> !calibration_failed_flag_q) // see RULE6
        else $error("Failed flag not cleared by write one.");
    AST_SINGLE: assert property (set_done && !cont_q && !cal_set
                                 |=> state_q == ADCCAL_IDLE) // see RULE7
        else $error("Single mode did not stop.");
    AST_AVG4: assert property (average_enable_q && average_count_select_q == 2'b00 && set_done
                               |-> smp_cnt_q == 6'd3) // see RULE9
        else $error("Average of four used wrong count.");
    AST_SAT: assert property (set_done && diff < 0
                              |=> result.data == 16'h0000) // see RULE11
        else $error("Negative result not saturated.");
    AST_RSVD: assert property (bus.rd && bus.addr == `ADCCAL_OFF_CTRL
                               |=> rdata[31:8] == 24'h00_0000 &&
                                   rdata[5:4] == 2'b00) // see RULE16
        else $error("Reserved bits read nonzero.");

    COV_CAL_OK: cover property (cal_end && !calibration_failed_flag_q ##1 !calibration_failed_flag_q);
    COV_CAL_FAIL: cover property (cal_end ##1 calibration_failed_flag_q);
    COV_AVG32: cover property (set_done && average_enable_q && average_count_select_q == 2'b11);
    COV_CONT: cover property (set_done && cont_q ##1 conv_active);

endmodule : adccal_core

// [tb/testbench.sv]
// Self-checking bench for the calibration, averaging and correction block.
// Assumes the package and the design file are compiled before this file.
`timescale 1ns/10ps
`include "adccal_params.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end end

module testbench
    import adccal_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              trigger_select = 1'b0;
    logic              stop_mode = 1'b0;
    logic              hw_trigger = 1'b0;
    adccal_bus_type    bus = '0;
    adccal_sample_type sample = '0;
    logic [31:0]       cal_measure = '0;
    logic [31:0]       rdata;
    logic              conv_start, conv_abort, conv_active, irq;
    adccal_sample_type result;
    logic [15:0]       gain_factor, sdata, ofs_v = '0;
    logic [16:0]       fix_v = '0;
    logic [63:0]       rd_q[$];
    logic [15:0]       res_q[$];
    logic              rd_pend = 1'b0, abort_seen = 1'b0;
    int bad_count = 0, check_count = 0, cycles = 0, seed = 32'h179f0658;
    int n_set = 1, acc = 0, got = 0, pend = 0;

    adccal_core adccal_core_i (.sys_clk(sys_clk), .rst(rst), .bus(bus),
        .rdata(rdata), .trigger_select(trigger_select),
        .stop_mode(stop_mode), .hw_trigger(hw_trigger), .sample(sample),
        .cal_measure(cal_measure), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_active(conv_active),
        .result(result), .gain_factor(gain_factor), .irq(irq));

    initial forever #25 sys_clk = ~sys_clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    function automatic logic [15:0] corr(input int v);
        v = v - int'($signed(ofs_v));
        return (v < 0) ? 16'h0000 : ((v > 65535) ? 16'hFFFF : v[15:0]);
    endfunction : corr

    // ------------------------------------------------------------------
    // Output watcher: takes the oldest note whenever a result appears.
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        logic [63:0] e;
        logic [15:0] r;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
        if (rd_pend) begin
            e = rd_q.pop_front();
            `CHK(rdata & ~e[63:32], e[31:0])
        end
        rd_pend <= bus.rd;
        if (result.valid === 1'b1) begin
            r = (res_q.size() > 0) ? res_q.pop_front() : ~result.data;
            `CHK(result.data, r)
        end
        if (conv_abort === 1'b1) abort_seen <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Analog core stand-in: answers each conversion three cycles later.
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        logic v;
        v = 1'b0;
        sdata = fix_v[16] ? fix_v[15:0] : 16'($random(seed));
        if (conv_abort === 1'b1) begin
            pend <= 0;
            res_q.delete();
            acc = 0;
            got = 0;
        end else if (conv_start === 1'b1) pend <= 3;
        else if (pend > 1) pend <= pend - 1;
        else if (pend == 1) begin
            pend <= 0;
            v = 1'b1;
            acc += sdata;
            got++;
            if (got == n_set) begin
                res_q.push_back(corr(acc / n_set));
                acc = 0;
                got = 0;
            end
        end
        sample <= '{v, sdata};
    end

    // ------------------------------------------------------------------
    // Register bus tasks.
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] v,
                      input logic [31:0] m = 32'h0000_0000);
        rd_q.push_back({m, v});
        @(posedge sys_clk) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge sys_clk) bus <= '0;
    endtask : rd

    task automatic idle_wait();
        @(posedge sys_clk);
        for (int i = 0; i < 2000 && conv_active !== 1'b0; i++)
            @(posedge sys_clk);
        // One more edge lets the watcher take the last result first.
        @(posedge sys_clk);
    endtask : idle_wait

    // Cause 1 writes a register, 2 selects hardware trigger, 3 stop mode.
    task automatic cal_run(input int how, input logic [31:0] exp_ctrl);
        cal_measure <= $random(seed);
        wr(`ADCCAL_OFF_CTRL, 32'h0000_0080);
        rd(`ADCCAL_OFF_CTRL, 32'h0000_0080, 32'h0000_003F);
        if (how == 1) wr(`ADCCAL_OFF_OFS, 32'h0000_0000);
        if (how == 2) trigger_select <= 1'b1;
        if (how == 3) stop_mode <= 1'b1;
        repeat (70) @(posedge sys_clk);
        trigger_select <= 1'b0;
        stop_mode <= 1'b0;
        rd(`ADCCAL_OFF_CTRL, exp_ctrl, 32'h0000_003F);
    endtask : cal_run

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        int          w[7] = '{6, 6, 10, 9, 8, 7, 6};
        logic [31:0] ctl_t[7] = '{4, 5, 6, 7, 0, 0, 0};
        logic [15:0] ofs_t[7] = '{0, 0, 0, 0, 16'h0100, 16'hFF00, 16'h0010};
        logic [16:0] fix_t[7] = '{0, 0, 0, 0, 17'h1_0050, 17'h1_FFF0, 0};
        int          cnt;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        `CHK(gain_factor, 16'h8000)
        rd(`ADCCAL_OFF_GAIN, 32'h0000_8000);
        rd(8'h10, 32'h0000_0000);
        wr(`ADCCAL_OFF_GAIN, 32'hFFFF_1234);
        rd(`ADCCAL_OFF_GAIN, 32'h0000_1234);
        `CHK(gain_factor, 16'h1234)
        wr(`ADCCAL_OFF_CTRL, 32'hFFFF_FF3F);
        rd(`ADCCAL_OFF_CTRL, 32'h0000_000F);
        wr(`ADCCAL_OFF_IRQMSK, 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            cal_run(k, (k == 0) ? 32'h0000_0000 : 32'h0000_0040);
            `CHK(irq, 1'b1)
            rd(`ADCCAL_OFF_IRQST, (k == 0) ? 32'h1 : 32'h3, 32'h4);
            wr(`ADCCAL_OFF_IRQST, 32'h0000_0007);
            rd(`ADCCAL_OFF_IRQST, 32'h0000_0000);
            `CHK(irq, 1'b0)
            if (k == 0) begin
                for (int i = 0; i < 7; i++)
                    rd(8'h34 + 8'(4 * i), (i == 1)
                       ? {26'h0, cal_measure[11:6]}
                       : cal_measure & 32'((1 << w[i]) - 1));
            end else begin
                wr(`ADCCAL_OFF_CTRL, 32'h0000_0000);
                rd(`ADCCAL_OFF_CTRL, 32'h0000_0040);
                wr(`ADCCAL_OFF_CTRL, 32'h0000_0040);
                rd(`ADCCAL_OFF_CTRL, 32'h0000_0000);
            end
        end
        for (int j = 0; j < 7; j++) begin
            n_set = ctl_t[j][2] ? (4 << ctl_t[j][1:0]) : 1;
            ofs_v = ofs_t[j];
            fix_v = fix_t[j];
            wr(`ADCCAL_OFF_CTRL, ctl_t[j]);
            wr(`ADCCAL_OFF_OFS, {16'hFFFF, ofs_v});
            rd(`ADCCAL_OFF_OFS, {16'h0000, ofs_v});
            if (j == 6) begin
                trigger_select <= 1'b1;
                @(posedge sys_clk) hw_trigger <= 1'b1;
                @(posedge sys_clk) hw_trigger <= 1'b0;
            end else wr(`ADCCAL_OFF_START, 32'h0000_0000);
            idle_wait();
            trigger_select <= 1'b0;
            `CHK(conv_active, 1'b0)
            `CHK(res_q.size(), 0)
        end
        wr(`ADCCAL_OFF_IRQMSK, 32'h0000_0000);
        wr(`ADCCAL_OFF_CTRL, 32'h0000_0008);
        wr(`ADCCAL_OFF_START, 32'h0000_0000);
        cnt = 0;
        for (int i = 0; i < 2000 && cnt < 3; i++) begin
            @(posedge sys_clk);
            if (result.valid === 1'b1) cnt++;
        end
        `CHK(conv_active, 1'b1)
        wr(`ADCCAL_OFF_CTRL, 32'h0000_0088);
        repeat (70) @(posedge sys_clk);
        `CHK(abort_seen, 1'b1)
        `CHK(conv_active, 1'b0)
        rd(`ADCCAL_OFF_CTRL, 32'h0000_0008);
        rd(`ADCCAL_OFF_IRQST, 32'h0000_0005);
        `CHK(irq, 1'b0)
        summarize();
    end
endmodule : testbench
